/* hw/simd_alu_pkg.sv */
// Package for the packed lane datapath: operation codes, modes, operand carriers.
// Assumes the core decode stage encodes operations with these enumerations.
package simd_alu_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned IMM_W = 6;
  localparam int unsigned EXT_ON = 1;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [3:0] SHAMT_MASK_H = 4'hf;
  localparam logic [3:0] SHAMT_MASK_B = 4'h7;

  typedef enum logic [4:0]
  {
    OP_ADD = 5'h00, OP_SUB = 5'h01, OP_AVG = 5'h02, OP_AVGU = 5'h03,
    OP_MIN = 5'h04, OP_MINU = 5'h05, OP_MAX = 5'h06, OP_MAXU = 5'h07,
    OP_SRL = 5'h08, OP_SRA = 5'h09, OP_SLL = 5'h0a, OP_OR = 5'h0b,
    OP_XOR = 5'h0c, OP_AND = 5'h0d, OP_ABS = 5'h0e, OP_EXT = 5'h0f,
    OP_EXTU = 5'h10, OP_INS = 5'h11
  } lane_op_e;

  typedef enum logic [2:0]
  {
    MODE_VV = 3'b001,
    MODE_SC = 3'b010,
    MODE_SCI = 3'b100
  } src2_mode_e;

  typedef struct packed
  {
    logic valid;
    lane_op_e op;
    src2_mode_e mode;
    logic byte_lanes;
    logic [5:0] imm;
    logic [31:0] src1;
    logic [31:0] src2;
    logic [31:0] dest_old;
  } alu_req_s;
endpackage

/* hw/packed_simd_alu.sv */
// Packed lane ALU: byte and halfword lane operations for the core execute stage.
// Assumes a registered request each cycle; result appears one clock later.
// Overview of operation
// - Lanes are computed separately; no carry crosses lane boundaries.
// - Packed operations exist only when the extension parameter equals one.
// - Byte form does four 8-bit operations per word.
// - Halfword form does two 16-bit operations per word.
// - Lane results truncate to lane width; no carry or overflow output.
// - Lane 0 is low bits; higher lanes follow upward in order.
// - Vector mode pairs same-index lanes of both sources.
// - Scalar mode copies low lane of source two to every lane.
// - Immediate mode extends six-bit immediate and copies it into every lane.
// - Immediate sign-extends by default, zero-extends for unsigned average, min and max, shifts, extract and insert.
// - Add gives lane sum masked to lane width.
// - Subtract gives first minus second lane, masked.
// - Signed average masks sum then shifts right arithmetically by one.
// - Unsigned average zero-extends immediate, masks sum, shifts right logically.
// - Signed min and max compare signed and pick smaller or larger.
// - Unsigned min and max zero-extend immediate and compare unsigned.
// - Shifts use four amount bits per halfword, three per byte.
// - Right shifts logical or arithmetic; left shift logical.
// - OR, XOR and AND act bitwise between paired lanes.
// - Absolute value negates negative lanes, passes others.
// - Extract picks lane by immediate, sign or zero extended to 32.
// - Insert writes low lane of source one into chosen lane only.
`timescale 1ns/100ps
module packed_simd_alu #(
  parameter int unsigned custom_ext_enable_param = 1
)
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input simd_alu_pkg::alu_req_s REQ,
  output logic RESULT_VALID,
  output logic ILLEGAL,
  output logic [31:0] RESULT
);

  localparam bit ENABLED = (custom_ext_enable_param == simd_alu_pkg::EXT_ON);

  // Immediate extension selection
  wire logic imm_zero_ext;
  wire logic [7:0] imm_b;
  wire logic [15:0] imm_h;
  assign imm_zero_ext = (REQ.op == simd_alu_pkg::OP_AVGU) ||
                        (REQ.op == simd_alu_pkg::OP_MINU) ||
                        (REQ.op == simd_alu_pkg::OP_MAXU) ||
                        (REQ.op == simd_alu_pkg::OP_SRL) ||
                        (REQ.op == simd_alu_pkg::OP_SRA) ||
                        (REQ.op == simd_alu_pkg::OP_SLL) ||
                        (REQ.op == simd_alu_pkg::OP_EXT) ||
                        (REQ.op == simd_alu_pkg::OP_EXTU) ||
                        (REQ.op == simd_alu_pkg::OP_INS);
  assign imm_b = imm_zero_ext ? {2'h0, REQ.imm} : {{2{REQ.imm[5]}}, REQ.imm};
  assign imm_h = imm_zero_ext ? {10'h000, REQ.imm} : {{10{REQ.imm[5]}}, REQ.imm};

  // Negative immediate is sign-extended before it meets each halfword lane
  property p_sci_sub_h;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && ENABLED && REQ.op == simd_alu_pkg::OP_SUB && !REQ.byte_lanes &&
     REQ.mode == simd_alu_pkg::MODE_SCI) |=>
    RESULT == {$past(REQ.src1[31:16]) - {{10{$past(REQ.imm[5])}}, $past(REQ.imm)},
               $past(REQ.src1[15:0]) - {{10{$past(REQ.imm[5])}}, $past(REQ.imm)}};
  endproperty
  a_sci_sub_h: assert property (p_sci_sub_h)
    else $error("immediate halfword subtract wrong");

  // Second operand formation per mode
  logic [31:0] op2;
  always_comb
  begin
    case (REQ.mode)
      simd_alu_pkg::MODE_VV: op2 = REQ.src2;
      simd_alu_pkg::MODE_SC: op2 = REQ.byte_lanes ? {4{REQ.src2[7:0]}} :
                                                   {2{REQ.src2[15:0]}};
      simd_alu_pkg::MODE_SCI: op2 = REQ.byte_lanes ? {4{imm_b}} : {2{imm_h}};
      default: op2 = REQ.src2;
    endcase
  end

  // Scalar copy of source two's low byte reaches every byte lane
  property p_sc_add_b;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && ENABLED && REQ.op == simd_alu_pkg::OP_ADD && REQ.byte_lanes &&
     REQ.mode == simd_alu_pkg::MODE_SC) |=>
    RESULT == {$past(REQ.src1[31:24]) + $past(REQ.src2[7:0]),
               $past(REQ.src1[23:16]) + $past(REQ.src2[7:0]),
               $past(REQ.src1[15:8]) + $past(REQ.src2[7:0]),
               $past(REQ.src1[7:0]) + $past(REQ.src2[7:0])};
  endproperty
  a_sc_add_b: assert property (p_sc_add_b)
    else $error("scalar byte add wrong");

  // One 16-bit lane operation; byte lanes use the low 8 bits with w8 set
  function automatic logic [15:0] lane_fn(input simd_alu_pkg::lane_op_e op,
                                          input logic w8, input logic [15:0] a,
                                          input logic [15:0] b);
    logic [15:0] sum;
    logic [15:0] dif;
    logic sa;
    logic sb;
    logic slt;
    logic ult;
    logic [3:0] sh;
    logic [15:0] sgnfill;
    logic [15:0] r;
    logic [15:0] m;
    logic [15:0] avg_top;
    sum = a + b;
    dif = a - b;
    m = w8 ? 16'h00ff : 16'hffff;
    sa = w8 ? a[7] : a[15];
    sb = w8 ? b[7] : b[15];
    ult = (a & m) < (b & m);
    slt = (sa != sb) ? sa : ult;
    sh = w8 ? (b[3:0] & simd_alu_pkg::SHAMT_MASK_B) :
              (b[3:0] & simd_alu_pkg::SHAMT_MASK_H);
    sgnfill = sa ? ~m : 16'h0000;
    avg_top = (w8 ? sum[7] : sum[15]) ? (m ^ (m >> 1)) : 16'h0000; // Lane sign back on top
    case (op)
      simd_alu_pkg::OP_ADD: r = sum;
      simd_alu_pkg::OP_SUB: r = dif;
      simd_alu_pkg::OP_AVG: r = ((sum & m) >> 1) | avg_top;
      simd_alu_pkg::OP_AVGU: r = (sum & m) >> 1;
      simd_alu_pkg::OP_MIN: r = slt ? a : b;
      simd_alu_pkg::OP_MAX: r = slt ? b : a;
      simd_alu_pkg::OP_MINU: r = ult ? a : b;
      simd_alu_pkg::OP_MAXU: r = ult ? b : a;
      simd_alu_pkg::OP_SRL: r = (a & m) >> sh;
      simd_alu_pkg::OP_SRA: r = (((a & m) | sgnfill) >> sh) |
                                (~(16'hffff >> sh) & {16{sa}});
      simd_alu_pkg::OP_SLL: r = a << sh;
      simd_alu_pkg::OP_OR: r = a | b;
      simd_alu_pkg::OP_XOR: r = a ^ b;
      simd_alu_pkg::OP_AND: r = a & b;
      simd_alu_pkg::OP_ABS: r = sa ? 16'h0000 - a : a;
      default: r = 16'h0000;
    endcase
    lane_fn = r & m;
  endfunction

  // Per-lane results, each lane fed only its own operand bits
  wire logic [31:0] res_b;
  wire logic [31:0] res_h;
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_byte
      wire logic [15:0] lr;
      assign lr = lane_fn(REQ.op, 1'b1, {8'h00, REQ.src1[8*g +: 8]}, {8'h00, op2[8*g +: 8]});
      assign res_b[8*g +: 8] = lr[7:0];
    end
    for (g = 0; g < 2; g++)
    begin : g_half
      assign res_h[16*g +: 16] = lane_fn(REQ.op, 1'b0, REQ.src1[16*g +: 16],
                                         op2[16*g +: 16]);
    end
  endgenerate

  // Absolute value of byte lane 0; the most negative code wraps to itself
  property p_abs_b;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && ENABLED && REQ.op == simd_alu_pkg::OP_ABS && REQ.byte_lanes) |=>
    RESULT[7:0] == ($past(REQ.src1[7]) ? 8'h00 - $past(REQ.src1[7:0]) : $past(REQ.src1[7:0]));
  endproperty
  a_abs_b: assert property (p_abs_b)
    else $error("byte absolute value wrong");

  // Logical right shift of halfword lane 0 by four amount bits
  property p_srl_h;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && ENABLED && REQ.op == simd_alu_pkg::OP_SRL && !REQ.byte_lanes &&
     REQ.mode == simd_alu_pkg::MODE_VV) |=>
    RESULT[15:0] == $past(REQ.src1[15:0]) >> $past(REQ.src2[3:0]);
  endproperty
  a_srl_h: assert property (p_srl_h)
    else $error("halfword logical shift wrong");

  // Arithmetic right shift of byte lane 0 fills with its own sign
  property p_sra_b;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && ENABLED && REQ.op == simd_alu_pkg::OP_SRA && REQ.byte_lanes &&
     REQ.mode == simd_alu_pkg::MODE_VV) |=>
    $signed(RESULT[7:0]) == ($signed($past(REQ.src1[7:0])) >>> $past(REQ.src2[2:0]));
  endproperty
  a_sra_b: assert property (p_sra_b)
    else $error("byte arithmetic shift wrong");

  // Unsigned byte maximum keeps the larger code of lane 0
  property p_maxu_b;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && ENABLED && REQ.op == simd_alu_pkg::OP_MAXU && REQ.byte_lanes &&
     REQ.mode == simd_alu_pkg::MODE_VV) |=>
    RESULT[7:0] == (($past(REQ.src1[7:0]) > $past(REQ.src2[7:0])) ?
                    $past(REQ.src1[7:0]) : $past(REQ.src2[7:0]));
  endproperty
  a_maxu_b: assert property (p_maxu_b)
    else $error("unsigned byte maximum wrong");

  // Signed halfword minimum of lane 1 compares with sign
  property p_min_h;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && ENABLED && REQ.op == simd_alu_pkg::OP_MIN && !REQ.byte_lanes &&
     REQ.mode == simd_alu_pkg::MODE_VV) |=>
    RESULT[31:16] == (($signed($past(REQ.src1[31:16])) < $signed($past(REQ.src2[31:16]))) ?
                      $past(REQ.src1[31:16]) : $past(REQ.src2[31:16]));
  endproperty
  a_min_h: assert property (p_min_h)
    else $error("signed halfword minimum wrong");

  // Extract and insert lane selection
  wire logic [7:0] ext_b;
  wire logic [15:0] ext_h;
  wire logic [31:0] extract_res;
  wire logic [31:0] insert_res;
  assign ext_b = REQ.src1[8*REQ.imm[1:0] +: 8];
  assign ext_h = REQ.src1[16*REQ.imm[0] +: 16];
  assign extract_res = REQ.byte_lanes ?
    ((REQ.op == simd_alu_pkg::OP_EXT) ? {{24{ext_b[7]}}, ext_b} : {24'h00_0000, ext_b}) :
    ((REQ.op == simd_alu_pkg::OP_EXT) ? {{16{ext_h[15]}}, ext_h} : {16'h0000, ext_h});
  assign insert_res = REQ.byte_lanes ?
    ((REQ.dest_old & ~(32'h0000_00ff << (8 * REQ.imm[1:0]))) |
     ({24'h00_0000, REQ.src1[7:0]} << (8 * REQ.imm[1:0]))) :
    ((REQ.dest_old & ~(32'h0000_ffff << (16 * REQ.imm[0]))) |
     ({16'h0000, REQ.src1[15:0]} << (16 * REQ.imm[0])));

  // Signed halfword extract picks the lane by immediate bit 0 and copies its sign up
  property p_ext_h;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && ENABLED && REQ.op == simd_alu_pkg::OP_EXT && !REQ.byte_lanes) |=>
    RESULT[15:0] == ($past(REQ.imm[0]) ? $past(REQ.src1[31:16]) : $past(REQ.src1[15:0])) &&
    RESULT[31:16] == {16{RESULT[15]}};
  endproperty
  a_ext_h: assert property (p_ext_h)
    else $error("signed halfword extract wrong");

  // Final result select
  wire logic is_known;
  wire logic [31:0] next_result;
  assign is_known = (REQ.op <= simd_alu_pkg::OP_INS);
  assign next_result = !ENABLED ? simd_alu_pkg::RESULT_RESET :
    ((REQ.op == simd_alu_pkg::OP_EXT) || (REQ.op == simd_alu_pkg::OP_EXTU)) ? extract_res :
    (REQ.op == simd_alu_pkg::OP_INS) ? insert_res :
    REQ.byte_lanes ? res_b : res_h;

  // Output registers
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      RESULT <= simd_alu_pkg::RESULT_RESET;
      RESULT_VALID <= 1'b0;
      ILLEGAL <= 1'b0;
    end
    else
    begin
      RESULT <= REQ.valid ? next_result : RESULT;
      RESULT_VALID <= REQ.valid && ENABLED && is_known;
      ILLEGAL <= REQ.valid && !(ENABLED && is_known);
    end
  end

  // Checks
  property p_disabled_illegal;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && !ENABLED) |=> (ILLEGAL && !RESULT_VALID);
  endproperty
  a_disabled_illegal: assert property (p_disabled_illegal)
    else $error("op accepted while disabled");

  property p_add_h;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && ENABLED && REQ.op == simd_alu_pkg::OP_ADD && !REQ.byte_lanes &&
     REQ.mode == simd_alu_pkg::MODE_VV) |=>
    RESULT == {$past(REQ.src1[31:16]) + $past(REQ.src2[31:16]),
               $past(REQ.src1[15:0]) + $past(REQ.src2[15:0])};
  endproperty
  a_add_h: assert property (p_add_h)
    else $error("halfword add wrong");

  property p_insert_keep;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && ENABLED && REQ.op == simd_alu_pkg::OP_INS && REQ.byte_lanes &&
     REQ.imm[1:0] == 2'h0) |=> RESULT[31:8] == $past(REQ.dest_old[31:8]);
  endproperty
  a_insert_keep: assert property (p_insert_keep)
    else $error("insert disturbed lanes");

  property p_extu_b;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && ENABLED && REQ.op == simd_alu_pkg::OP_EXTU && REQ.byte_lanes) |=>
    RESULT[31:8] == 24'h00_0000;
  endproperty
  a_extu_b: assert property (p_extu_b)
    else $error("unsigned extract not zero extended");

  // A known operation with the extension on answers with a valid pulse only
  property p_valid_pulse;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && ENABLED && REQ.op <= simd_alu_pkg::OP_INS) |=> (RESULT_VALID && !ILLEGAL);
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("known op not answered as valid");

  // An unknown operation code is refused and clears the result
  property p_unknown_refused;
    @(posedge CLOCK) disable iff (!RSTN)
    (REQ.valid && REQ.op > simd_alu_pkg::OP_INS) |=>
    (ILLEGAL && !RESULT_VALID && RESULT == simd_alu_pkg::RESULT_RESET);
  endproperty
  a_unknown_refused: assert property (p_unknown_refused)
    else $error("unknown op not refused");
endmodule

/* tb/simd_operand_source.sv */
// Operand source model: decode stage and register file feeding one request a cycle.
// Assumes the bench sets the wanted request away from the falling edge.
`timescale 1ns/100ps
module simd_operand_source
(
  input wire logic clock,
  input wire logic rstn,
  input simd_alu_pkg::alu_req_s want,
  output simd_alu_pkg::alu_req_s req
);
  // Drive on the falling edge; idle operand lines turn over so stale data never looks valid
  always_ff @(negedge clock or negedge rstn)
  begin
    if (!rstn)
      req <= '0;
    else if (want.valid)
    begin
      req <= want;
      if (want.op inside {5'h08, 5'h09, 5'h0a})
      begin
        req.imm <= want.imm & (want.byte_lanes ? 6'h07 : 6'h0f);
        req.src2 <= want.src2 & (want.byte_lanes ? 32'h0707_0707 : 32'h000f_000f);
      end
    end
    else
    begin
      req.valid <= 1'b0;
      req.src1 <= ~req.src1;
      req.src2 <= ~req.src2;
      req.dest_old <= ~req.dest_old;
    end
  end
endmodule

/* tb/packed_simd_alu_test.sv */
// Bench for the packed lane datapath: lane ops, lane pick and insert, refusal, hold.
// Assumes the operand source model presents requests on the falling edge.
`timescale 1ns/100ps
module packed_simd_alu_test;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  simd_alu_pkg::alu_req_s nxt = '0;
  simd_alu_pkg::alu_req_s req;
  logic ok, bad, ok_off, bad_off;
  logic [31:0] res, res_off, last;
  int n_fail = 0;
  int checks_done = 0;
  // Clock, operand source, enabled and disabled datapaths
  initial forever #50 clock = ~clock;
  simd_operand_source u_simd_operand_source (.clock(clock), .rstn(rstn), .want(nxt), .req(req));
  packed_simd_alu u_packed_simd_alu (.CLOCK(clock), .RSTN(rstn), .REQ(req),
    .RESULT_VALID(ok), .ILLEGAL(bad), .RESULT(res));
  packed_simd_alu #(.custom_ext_enable_param(0)) u_packed_simd_alu_off (.CLOCK(clock),
    .RSTN(rstn), .REQ(req), .RESULT_VALID(ok_off), .ILLEGAL(bad_off), .RESULT(res_off));
  // Lane reference built from lane width, sign bit and mask
  function automatic logic [31:0] model(simd_alu_pkg::alu_req_s r);
    int w, m, h, a, b, sa, sb, v, sel;
    logic [31:0] y;
    logic zx;
    w = r.byte_lanes ? 8 : 16;
    m = (1 << w) - 1;
    h = 1 << (w - 1);
    zx = r.op inside {5'h03, 5'h05, 5'h07, 5'h08, 5'h09, 5'h0a};
    y = 32'h0000_0000;
    sel = r.byte_lanes ? r.imm[1:0] : r.imm[0];
    a = (r.src1 >> (sel * w)) & m;
    if (r.op == 5'h0f) return (a ^ h) - h;
    if (r.op == 5'h10) return a;
    if (r.op == 5'h11) return (r.dest_old & ~(m << (sel * w))) | ((r.src1 & m) << (sel * w));
    for (int i = 0; i < 32 / w; i++)
    begin
      a = (r.src1 >> (i * w)) & m;
      b = r.mode == 3'h4 ? (zx ? r.imm : {{26{r.imm[5]}}, r.imm})
        : r.src2 >> (r.mode == 3'h2 ? 0 : i * w);
      b = b & m;
      sa = (a ^ h) - h;
      sb = (b ^ h) - h;
      case (r.op)
        5'h00: v = a + b;
        5'h01: v = a - b;
        5'h02: v = ((((a + b) & m) ^ h) - h) >>> 1;
        5'h03: v = ((a + b) & m) >> 1;
        5'h04: v = sa < sb ? a : b;
        5'h05: v = a < b ? a : b;
        5'h06: v = sa > sb ? a : b;
        5'h07: v = a > b ? a : b;
        5'h08: v = a >> (b & (w - 1));
        5'h09: v = sa >>> (b & (w - 1));
        5'h0a: v = a << (b & (w - 1));
        5'h0b: v = a | b;
        5'h0c: v = a ^ b;
        5'h0d: v = a & b;
        default: v = sa < 0 ? -sa : a;
      endcase
      y = y | ((v & m) << (i * w));
    end
    return y;
  endfunction
  // One comparison, reported on mismatch
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // Issue one request and judge the answer one cycle later on both datapaths
  task automatic go(int op, int md, logic bl, logic [5:0] im, logic [31:0] a, b, d);
    logic lg;
    nxt = {1'b1, simd_alu_pkg::lane_op_e'(op), simd_alu_pkg::src2_mode_e'(md), bl, im, a, b, d};
    lg = op <= 17;
    last = lg ? model(nxt) : 32'h0000_0000;
    @(posedge clock);
    #1;
    chk("valid", {31'h0, lg}, ok);
    chk("illegal", {31'h0, !lg}, bad);
    chk("off valid", 32'h0000_0000, ok_off);
    chk("result", last, res);
    chk("off illegal", 32'h0000_0001, bad_off);
    chk("off result", 32'h0000_0000, res_off);
  endtask
  // Idle cycle: result holds, no valid pulse
  task automatic idle();
    nxt.valid = 1'b0;
    @(posedge clock);
    #1;
    chk("hold", last, res);
    chk("idle valid", 32'h0000_0000, ok);
  endtask
  // Every lane operation in every source mode and width, boundary operands
  task automatic t_ops();
    for (int op = 0; op < 15; op++)
      for (int md = 1; md < 5; md = md * 2)
        for (int bl = 0; bl < 2; bl++)
        begin
          go(op, md, bl, 6'h2a, 32'h80ff_7f01, 32'h7f81_01ff, 0);
          go(op, md, bl, 6'h1d, 32'h0123_fedc, 32'h4329_876b, 0);
        end
    idle();
    $display("t_ops done");
  endtask
  // Lane extract and insert for every lane with upper immediate bits set
  task automatic t_bits();
    for (int op = 15; op < 18; op++)
      for (int s = 0; s < 8; s++)
        go(op, 4, s[2], 6'h3c | s[1:0], 32'h700d_817f, 0, 32'h1234_5678);
    idle();
    $display("t_bits done");
  endtask
  // Unknown operation codes are refused and clear the result
  task automatic t_refuse();
    go(5'h12, 1, 0, 0, 32'h1111_2222, 32'h3333_4444, 0);
    go(5'h1f, 2, 1, 0, 32'h5555_6666, 32'h7777_8888, 0);
    idle();
    $display("t_refuse done");
  endtask
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clock);
    chk("reset result", 32'h0000_0000, res);
    @(negedge clock);
    rstn = 1'b1;
    @(posedge clock);
    #1;
    last = 32'h0000_0000;
    t_ops();
    t_bits();
    t_refuse();
    end_of_test();
  end
  // Watchdog
  initial
  begin
    #1_000_000;
    n_fail++;
    end_of_test();
  end
endmodule
